/* File: fsr_params.svh */
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// ======================================================================
// Command codes
`define FSR_CMD_WR_ALLOW     8'h06
`define FSR_CMD_WR_FORBID    8'h04
`define FSR_CMD_RD_SR1       8'h05
`define FSR_CMD_RD_SR2       8'h35
`define FSR_CMD_RD_SR3       8'h15
`define FSR_CMD_WR_SR1       8'h01
`define FSR_CMD_WR_SR2       8'h31
`define FSR_CMD_WR_SR3       8'h11
`define FSR_CMD_PAGE_WR      8'h02
`define FSR_CMD_PAGE_WR_Q    8'h32
`define FSR_CMD_PAGE_WR_F    8'hF2
`define FSR_CMD_SECT_WIPE    8'h20
`define FSR_CMD_BLK32_WIPE   8'h52
`define FSR_CMD_BLK64_WIPE   8'hD8
`define FSR_CMD_FULL_WIPE_A  8'h60
`define FSR_CMD_FULL_WIPE_B  8'hC7
`define FSR_CMD_SUSPEND      8'h75
`define FSR_CMD_RESUME       8'h7A
`define FSR_CMD_RST_ENABLE   8'h66
`define FSR_CMD_RST          8'h99

// ======================================================================
// Frame lengths in whole bytes
`define FSR_LEN_SIMPLE       4'h1
`define FSR_LEN_SR_WRITE     4'h2
`define FSR_LEN_WIPE         4'h4
`define FSR_LEN_PAGE_MIN     4'h5

// ======================================================================
// Status bit positions
`define FSR_BIT_WIP          0
`define FSR_BIT_WEL          1
`define FSR_BIT_BP_LO        2
`define FSR_BIT_LOCK0        7
`define FSR_BIT_LOCK1        8
`define FSR_BIT_QE           9
`define FSR_BIT_PSUS         10
`define FSR_BIT_LB_LO        11
`define FSR_BIT_CMP          14
`define FSR_BIT_ESUS         15
`define FSR_BIT_FAST         20
`define FSR_BIT_DRV_LO       21

// ======================================================================
// Reset values and masks
`define FSR_RST_BP           5'h00
`define FSR_RST_LOCK         2'h0
`define FSR_LOCK_PWR_DOWN    2'h2
`define FSR_RST_DRV          2'h1
`define FSR_NV_MASK          24'h67FBFC

// ======================================================================
// Array geometry
`define FSR_ARRAY_BYTES      23'h400000
`define FSR_BLK64_BYTES      23'h010000
`define FSR_BLK32_BYTES      23'h008000
`define FSR_SECT_BYTES       23'h001000
`define FSR_PAGE_LAST        22'h0000FF

// ======================================================================
// Timing
`define FSR_CLK_MHZ          200
`define FSR_T_SR_WRITE_NS    2000
`define FSR_SR_WRITE_CYC     ((`FSR_T_SR_WRITE_NS*`FSR_CLK_MHZ+999)/1000)

`endif

/* File: fsr_pkg.sv */
package fsr_pkg;

  // Control flow of the register side
  typedef enum logic [1:0] {
    FSR_IDLE = 2'b00,
    FSR_EXEC = 2'b01,
    FSR_SRWR = 2'b11
  } fsr_state_t;

  // Operation handed to the array engine
  typedef enum logic [2:0] {
    FSR_OP_PAGE  = 3'h0,
    FSR_OP_SECT  = 3'h1,
    FSR_OP_BLK32 = 3'h2,
    FSR_OP_BLK64 = 3'h3,
    FSR_OP_FULL  = 3'h4
  } fsr_op_t;

endpackage

/* File: fsr_status_regs.sv */
`timescale 1ns/100ps
`include "fsr_params.svh"
module fsr_status_regs (
  input  wire logic            sys_clk_i,
  input  wire logic            arst_n_i,
  input  wire logic            spi_sclk_i,
  input  wire logic            spi_cs_n_i,
  input  wire logic            spi_si_i,
  output logic                 spi_so_o,
  output logic                 spi_so_oe_o,
  input  wire logic            write_guard_pin_n_i,
  input  wire logic            array_busy_i,
  input  wire logic            high_throughput_mode_i,
  input  wire logic [23:0]     nv_image_i,
  output logic                 nv_store_o,
  output logic [23:0]          nv_image_o,
  output logic                 array_start_o,
  output fsr_pkg::fsr_op_t     array_op_o,
  output logic [21:0]          array_addr_o,
  output logic                 array_suspend_o,
  output logic                 array_resume_o,
  output logic                 soft_reset_o,
  output logic                 four_lane_enable_o,
  output logic [1:0]           output_strength_o,
  output logic [2:0]           security_lock_o
);
  import fsr_pkg::*;

  // ====================================================================
  // Link side capture
  logic        fresh;
  logic [6:0]  shreg;
  logic [2:0]  bitpos;
  logic [3:0]  bytes;
  logic [7:0]  link_cmd;
  logic [7:0]  link_dat;
  logic [23:0] link_addr;
  logic [7:0]  full_byte;
  logic [23:0] snap;
  logic [7:0]  rd_byte;
  logic        rd_cmd;

  assign full_byte = {shreg, spi_si_i};

  always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_ff @(posedge spi_sclk_i) begin
    if (fresh) begin
      shreg  <= {6'h00, spi_si_i};
      bitpos <= 3'h1;
      bytes  <= 4'h0;
    end else begin
      shreg  <= full_byte[6:0];
      bitpos <= bitpos + 3'h1;
      if (bitpos == 3'h7 && bytes != 4'hF) begin
        bytes <= bytes + 4'h1;
      end
    end
  end

  always_ff @(posedge spi_sclk_i) begin
    if (!fresh && bitpos == 3'h7) begin
      unique case (bytes)
        4'h0: link_cmd <= full_byte;
        4'h1: begin
          link_dat          <= full_byte;
          link_addr[23:16]  <= full_byte;
        end
        4'h2: link_addr[15:8] <= full_byte;
        4'h3: link_addr[7:0]  <= full_byte;
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_cmd  = 1'b1;
    rd_byte = snap[7:0];
    unique case (link_cmd)
      `FSR_CMD_RD_SR1: rd_byte = snap[7:0];
      `FSR_CMD_RD_SR2: rd_byte = snap[15:8];
      `FSR_CMD_RD_SR3: rd_byte = snap[23:16];
      default:         rd_cmd  = 1'b0;
    endcase
  end

  always_ff @(negedge spi_sclk_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      spi_so_oe_o <= 1'b0;
      spi_so_o    <= 1'b0;
    end else begin
      spi_so_oe_o <= rd_cmd && bytes != 4'h0;
      spi_so_o    <= rd_byte[3'h7 - bitpos];
    end
  end

  // ====================================================================
  // Synchronisers
  logic cs_meta, cs_sync, cs_prev;
  logic wp_meta, wp_sync;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      cs_meta <= spi_cs_n_i;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= write_guard_pin_n_i;
      wp_sync <= wp_meta;
    end
  end

  // ====================================================================
  // Register state
  fsr_state_t  state;
  logic [15:0] timer;
  logic        write_latch_flag, esus, psus, qe, cmp, rst_armed, nv_loaded;
  logic [4:0]  bp;
  logic [1:0]  lock, drv;
  logic [2:0]  lb;
  logic [23:0] status;
  fsr_op_t     cur_op;

  // Busy covers array and status write
  logic write_in_progress_flag;
  assign write_in_progress_flag = array_busy_i || timer != 16'h0000;

  always_comb begin
    status                        = 24'h000000;
    status[`FSR_BIT_WIP]          = write_in_progress_flag;
    status[`FSR_BIT_WEL]          = write_latch_flag;
    status[`FSR_BIT_BP_LO +: 5]   = bp;
    status[`FSR_BIT_LOCK0]        = lock[0];
    status[`FSR_BIT_LOCK1]        = lock[1];
    status[`FSR_BIT_QE]           = qe;
    status[`FSR_BIT_PSUS]         = psus;
    status[`FSR_BIT_LB_LO +: 3]   = lb;
    status[`FSR_BIT_CMP]          = cmp;
    status[`FSR_BIT_ESUS]         = esus;
    status[`FSR_BIT_FAST]         = high_throughput_mode_i;
    status[`FSR_BIT_DRV_LO +: 2]  = drv;
  end

  // Snapshot taken after frame start, stable for the link side
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap <= 24'h000000;
    end else if (!cs_sync && cs_prev) begin
      snap <= status;
    end
  end

  // ====================================================================
  // Protection map
  function automatic logic guarded(input logic [21:0] a,
                                   input logic [4:0]  g,
                                   input logic        inv);
    logic [22:0] size;
    logic        hit;
    size = 23'h000000;
    hit  = 1'b0;
    if (g[2:0] == 3'h7) begin
      hit = 1'b1;
    end else if (g[2:0] != 3'h0) begin
      if (!g[4]) begin
        size = `FSR_BLK64_BYTES << (g[2:0] - 3'h1);
      end else if (g[2]) begin
        size = `FSR_BLK32_BYTES;
      end else begin
        size = `FSR_SECT_BYTES << (g[1:0] - 2'h1);
      end
      hit = g[3] ? ({1'b0, a} < size)
                 : ({1'b0, a} >= (`FSR_ARRAY_BYTES - size));
    end
    return hit ^ inv;
  endfunction

  // ====================================================================
  // Command decode
  logic       frame_ok, sr_unlocked, wp_high;
  logic       do_write_allow_command, do_write_forbid_command, do_srw, do_arr, do_susp, do_res;
  logic       do_arm, do_rst;
  logic [21:0] a_lo, a_hi;
  fsr_op_t    next_op;

  assign frame_ok = bitpos == 3'h0 && bytes != 4'h0;
  // Pin acts as data lane when four lanes are on
  assign wp_high  = wp_sync || qe;

  always_comb begin
    unique case (lock)
      2'h0: sr_unlocked = 1'b1;
      2'h1: sr_unlocked = wp_high;
      default: sr_unlocked = 1'b0;
    endcase
  end

  always_comb begin
    do_write_allow_command = 1'b0;
    do_write_forbid_command = 1'b0;
    do_srw  = 1'b0;
    do_arr  = 1'b0;
    do_susp = 1'b0;
    do_res  = 1'b0;
    do_arm  = 1'b0;
    do_rst  = 1'b0;
    next_op = FSR_OP_PAGE;
    a_lo    = link_addr[21:0];
    a_hi    = link_addr[21:0];
    if (state == FSR_EXEC && frame_ok) begin
      unique case (link_cmd)
        `FSR_CMD_WR_ALLOW:
          do_write_allow_command = !write_in_progress_flag && bytes == `FSR_LEN_SIMPLE;
        `FSR_CMD_WR_FORBID:
          do_write_forbid_command = !write_in_progress_flag && bytes == `FSR_LEN_SIMPLE;
        `FSR_CMD_WR_SR1, `FSR_CMD_WR_SR2, `FSR_CMD_WR_SR3:
          do_srw = !write_in_progress_flag && write_latch_flag && sr_unlocked &&
                   bytes == `FSR_LEN_SR_WRITE;
        `FSR_CMD_PAGE_WR, `FSR_CMD_PAGE_WR_Q, `FSR_CMD_PAGE_WR_F: begin
          a_hi   = link_addr[21:0] | `FSR_PAGE_LAST;
          do_arr = !write_in_progress_flag && write_latch_flag && bytes >= `FSR_LEN_PAGE_MIN &&
                   !guarded(a_lo, bp, cmp);
        end
        // Wipe guard on both ends of the unit
        `FSR_CMD_SECT_WIPE, `FSR_CMD_BLK32_WIPE,
        `FSR_CMD_BLK64_WIPE: begin
          if (link_cmd == `FSR_CMD_SECT_WIPE) begin
            next_op = FSR_OP_SECT;
            a_lo    = link_addr[21:0] & ~22'h000FFF;
          end else if (link_cmd == `FSR_CMD_BLK32_WIPE) begin
            next_op = FSR_OP_BLK32;
            a_lo    = link_addr[21:0] & ~22'h007FFF;
          end else begin
            next_op = FSR_OP_BLK64;
            a_lo    = link_addr[21:0] & ~22'h00FFFF;
          end
          a_hi   = a_lo | (next_op == FSR_OP_SECT  ? 22'h000FFF :
                           next_op == FSR_OP_BLK32 ? 22'h007FFF :
                                                     22'h00FFFF);
          do_arr = !write_in_progress_flag && write_latch_flag && bytes == `FSR_LEN_WIPE &&
                   !guarded(a_lo, bp, cmp) && !guarded(a_hi, bp, cmp);
        end
        `FSR_CMD_FULL_WIPE_A, `FSR_CMD_FULL_WIPE_B: begin
          next_op = FSR_OP_FULL;
          do_arr  = !write_in_progress_flag && write_latch_flag && bytes == `FSR_LEN_SIMPLE &&
                    ((bp[2:0] == 3'h0 && !cmp) ||
                     (bp[2:0] == 3'h7 && cmp));
        end
        `FSR_CMD_SUSPEND:
          do_susp = array_busy_i && !esus && !psus;
        `FSR_CMD_RESUME:
          do_res = 1'b1;
        `FSR_CMD_RST_ENABLE:
          do_arm = 1'b1;
        `FSR_CMD_RST:
          do_rst = rst_armed;
        default: ;
      endcase
    end
  end

  // ====================================================================
  // Sequencing and status-write timer
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= FSR_IDLE;
    end else begin
      unique case (state)
        FSR_IDLE: if (cs_sync && !cs_prev) begin
          state <= FSR_EXEC;
        end
        FSR_EXEC: begin
          if (do_srw || (timer > 16'h0001 && !do_rst)) begin
            state <= FSR_SRWR;
          end else begin
            state <= FSR_IDLE;
          end
        end
        FSR_SRWR: begin
          if (cs_sync && !cs_prev) begin
            state <= FSR_EXEC;
          end else if (timer == 16'h0000) begin
            state <= FSR_IDLE;
          end
        end
        default: state <= FSR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer <= 16'h0000;
    end else if (do_srw) begin
      timer <= 16'(`FSR_SR_WRITE_CYC);
    end else if (do_rst) begin
      timer <= 16'h0000;
    end else if (timer != 16'h0000) begin
      timer <= timer - 16'h0001;
    end
  end

  // ====================================================================
  // Write latch
  // Latch set and clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      write_latch_flag <= 1'b0;
    end else if (do_write_forbid_command || do_srw || do_arr || do_rst) begin
      write_latch_flag <= 1'b0;
    end else if (do_write_allow_command) begin
      write_latch_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_armed <= 1'b0;
    end else if (state == FSR_EXEC && frame_ok) begin
      rst_armed <= do_arm;
    end
  end

  // ====================================================================
  // Non-volatile bits
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nv_loaded <= 1'b0;
      bp        <= `FSR_RST_BP;
      lock      <= `FSR_RST_LOCK;
      qe        <= 1'b0;
      lb        <= 3'h0;
      cmp       <= 1'b0;
      drv       <= `FSR_RST_DRV;
    end else if (!nv_loaded) begin
      nv_loaded <= 1'b1;
      bp        <= nv_image_i[`FSR_BIT_BP_LO +: 5];
      lock      <= ({nv_image_i[`FSR_BIT_LOCK1],
                     nv_image_i[`FSR_BIT_LOCK0]} == `FSR_LOCK_PWR_DOWN) ?
                   `FSR_RST_LOCK :
                   {nv_image_i[`FSR_BIT_LOCK1], nv_image_i[`FSR_BIT_LOCK0]};
      qe        <= nv_image_i[`FSR_BIT_QE];
      lb        <= nv_image_i[`FSR_BIT_LB_LO +: 3];
      cmp       <= nv_image_i[`FSR_BIT_CMP];
      drv       <= nv_image_i[`FSR_BIT_DRV_LO +: 2];
    end else if (do_srw) begin
      unique case (link_cmd)
        `FSR_CMD_WR_SR1: begin
          bp      <= link_dat[`FSR_BIT_BP_LO +: 5];
          lock[0] <= link_dat[`FSR_BIT_LOCK0];
        end
        `FSR_CMD_WR_SR2: begin
          lock[1] <= link_dat[`FSR_BIT_LOCK1 - 8];
          qe      <= link_dat[`FSR_BIT_QE - 8];
          lb      <= lb | link_dat[`FSR_BIT_LB_LO - 8 +: 3];
          cmp     <= link_dat[`FSR_BIT_CMP - 8];
        end
        default: begin
          drv <= link_dat[`FSR_BIT_DRV_LO - 16 +: 2];
        end
      endcase
    end
  end

  // ====================================================================
  // Paused flags
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      esus <= 1'b0;
      psus <= 1'b0;
    end else if (do_susp) begin
      esus <= cur_op != FSR_OP_PAGE;
      psus <= cur_op == FSR_OP_PAGE;
    end else if (do_res || do_rst) begin
      esus <= 1'b0;
      psus <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_op <= FSR_OP_PAGE;
    end else if (do_arr) begin
      cur_op <= next_op;
    end
  end

  // ====================================================================
  // Outputs
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      array_start_o      <= 1'b0;
      array_op_o         <= FSR_OP_PAGE;
      array_addr_o       <= 22'h000000;
      array_suspend_o    <= 1'b0;
      array_resume_o     <= 1'b0;
      soft_reset_o       <= 1'b0;
      nv_store_o         <= 1'b0;
      nv_image_o         <= 24'h000000;
      four_lane_enable_o <= 1'b0;
      output_strength_o  <= `FSR_RST_DRV;
      security_lock_o    <= 3'h0;
    end else begin
      array_start_o      <= do_arr;
      if (do_arr) begin
        array_op_o   <= next_op;
        array_addr_o <= a_lo;
      end
      array_suspend_o    <= do_susp;
      array_resume_o     <= do_res && (esus || psus);
      soft_reset_o       <= do_rst;
      nv_store_o         <= timer == 16'h0001 && !do_rst;
      nv_image_o         <= status & `FSR_NV_MASK;
      four_lane_enable_o <= qe;
      output_strength_o  <= drv;
      security_lock_o    <= lb;
    end
  end

endmodule

/* File: fsr_status_regs_chk.sv */
`timescale 1ns/100ps
module fsr_status_regs_chk (
  input wire logic             sys_clk_i,
  input wire logic             arst_n_i,
  input wire logic             array_busy_i,
  input wire logic             nv_store_o,
  input wire logic [23:0]      nv_image_o,
  input wire logic             array_start_o,
  input wire fsr_pkg::fsr_op_t array_op_o,
  input wire logic [21:0]      array_addr_o,
  input wire logic             array_suspend_o,
  input wire logic             soft_reset_o,
  input wire logic             four_lane_enable_o,
  input wire logic [1:0]       output_strength_o,
  input wire logic [2:0]       security_lock_o
);
  import fsr_pkg::*;
  // ====================================================
  // Checks
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_image_rsvd: assert property ((nv_image_o & 24'h9F0403) == 24'h0)
    else $error("image holds reserved bits");
  a_lane_mirror: assert property (
    nv_store_o |-> four_lane_enable_o == nv_image_o[9])
    else $error("four lane level differs");
  a_drv_mirror: assert property (
    nv_store_o |-> output_strength_o == nv_image_o[22:21])
    else $error("strength level differs");
  a_lock_mirror: assert property (
    nv_store_o |-> security_lock_o == nv_image_o[13:11])
    else $error("security lock level differs");
  a_lock_sticky: assert property (
    (security_lock_o & $past(security_lock_o)) == $past(security_lock_o))
    else $error("security lock cleared");
  a_suspend_busy: assert property (
    array_suspend_o |-> $past(array_busy_i))
    else $error("suspend while idle");
  a_start_idle: assert property (array_start_o |-> !$past(array_busy_i))
    else $error("start while busy");
  a_sect_align: assert property (
    array_start_o && array_op_o == FSR_OP_SECT |-> array_addr_o[11:0] == 12'h0)
    else $error("sector start unaligned");
  a_store_gap: assert property (nv_store_o |=> !nv_store_o [*8])
    else $error("store too soon");
  a_reset_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset not a pulse");
endmodule
bind fsr_status_regs fsr_status_regs_chk i_chk (.sys_clk_i, .arst_n_i,
  .array_busy_i, .nv_store_o, .nv_image_o, .array_start_o, .array_op_o,
  .array_addr_o, .array_suspend_o, .soft_reset_o, .four_lane_enable_o,
  .output_strength_o, .security_lock_o);

/* File: fsr_host_model.sv */
`timescale 1ns/100ps
module fsr_host_model (
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_si_o,
  input  wire logic spi_so_i,
  input  wire logic spi_so_oe_i
);
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_si_o = 1'b0;
  end
  // ====================================================
  // Frame, bytes from the top of d, MSB first
  // pins driven, never tied
  task automatic xfer(input logic [39:0] d, input int nb,
                      output logic [7:0] rd);
    int i;
    rd = 8'h00;
    spi_cs_n_o = 1'b0;
    #30;
    for (i = 0; i < nb * 8; i++) begin
      spi_si_o = d[39-i];
      #3 spi_sclk_o = 1'b1;
      rd = {rd[6:0], spi_so_oe_i ? spi_so_i : 1'bz};
      #3 spi_sclk_o = 1'b0;
    end
    #3 spi_cs_n_o = 1'b1;
    spi_si_o = ~spi_si_o;
    #40;
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
`include "fsr_params.svh"
module testbench;
  import fsr_pkg::*;
  logic        sys_clk_i, arst_n_i, spi_sclk_i, spi_cs_n_i, spi_si_i;
  logic        spi_so_o, spi_so_oe_o, write_guard_pin_n_i, array_busy_i;
  logic        high_throughput_mode_i, nv_store_o, array_start_o;
  logic        array_suspend_o, array_resume_o, soft_reset_o;
  logic        four_lane_enable_o;
  logic [23:0] nv_image_i, nv_image_o;
  logic [21:0] array_addr_o;
  logic [1:0]  output_strength_o;
  logic [2:0]  security_lock_o;
  logic [7:0]  rd;
  fsr_op_t     array_op_o;
  int          fail_count, total_checks, bcnt;
  int          cnt [5];
  logic [47:0] ptab [10] = '{48'h00043F000000, 48'h00043E000001,
    48'h40043F000001, 48'h40043E000000, 48'h40443FF00001,
    48'h40443FE00000, 48'h406400000001, 48'h406400100000,
    48'h401C00000001, 48'h40003FF00000};

  fsr_status_regs i_dut (.sys_clk_i, .arst_n_i, .spi_sclk_i, .spi_cs_n_i,
    .spi_si_i, .spi_so_o, .spi_so_oe_o, .write_guard_pin_n_i, .array_busy_i,
    .high_throughput_mode_i, .nv_image_i, .nv_store_o, .nv_image_o,
    .array_start_o, .array_op_o, .array_addr_o, .array_suspend_o,
    .array_resume_o, .soft_reset_o, .four_lane_enable_o, .output_strength_o,
    .security_lock_o);
  fsr_host_model i_host (.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i),
    .spi_si_o(spi_si_i), .spi_so_i(spi_so_o), .spi_so_oe_i(spi_so_oe_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ====================================================
  // Pulse counts and array engine stand-in
  always @(posedge sys_clk_i) begin
    cnt[0] <= cnt[0] + int'(array_start_o);
    cnt[1] <= cnt[1] + int'(nv_store_o);
    cnt[2] <= cnt[2] + int'(array_suspend_o);
    cnt[3] <= cnt[3] + int'(array_resume_o);
    cnt[4] <= cnt[4] + int'(soft_reset_o);
  end
  always @(negedge sys_clk_i) begin
    if (array_start_o || array_resume_o) array_busy_i <= 1'b1;
    else if (array_suspend_o || bcnt == 1) array_busy_i <= 1'b0;
    if (array_start_o) bcnt <= 60;
    else if (array_busy_i && bcnt > 0) bcnt <= bcnt - 1;
  end
  // ====================================================
  // Tasks
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] a = 32'h0,
                     input int nb = 1);
    i_host.xfer({c, a}, nb, rd);
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
    cmd(c, 32'h0, 2);
    chk(24'(rd), 24'(e));
  endtask
  task automatic wr(input logic [7:0] c, d, input logic we, ok);
    int n;
    n = cnt[1];
    if (we) cmd(`FSR_CMD_WR_ALLOW);
    cmd(c, {d, 24'h0}, 2);
    idle(`FSR_SR_WRITE_CYC + 20);
    chk(24'(cnt[1] - n), 24'(ok));
  endtask
  task automatic wipe(input logic [7:0] c, input logic [23:0] a,
                      input int nb, input logic ok);
    int n;
    n = cnt[0];
    cmd(`FSR_CMD_WR_ALLOW);
    cmd(c, {a, 8'h0}, nb);
    idle(80);
    chk(24'(cnt[0] - n), 24'(ok));
    if (ok && nb > 1) chk(24'(array_addr_o), 24'(a[21:0]));
  endtask
  task automatic pwr();
    @(negedge sys_clk_i);
    nv_image_i = nv_image_o;
    arst_n_i = 1'b0;
    idle(2);
    arst_n_i = 1'b1;
    idle(4);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  // ====================================================
  // Sequence
  initial begin
    arst_n_i = 1'b0;
    write_guard_pin_n_i = 1'b1;
    array_busy_i = 1'b0;
    high_throughput_mode_i = 1'b0;
    nv_image_i = 24'hAF0000;
    bcnt = 0;
    cnt = '{default: 0};
    idle(12);
    chk(24'(output_strength_o), 24'h1);
    chk(24'({four_lane_enable_o, security_lock_o}), 24'h0);
    arst_n_i = 1'b1;
    idle(4);
    rdchk(8'h15, 8'h20);
    rdchk(8'h05, 8'h00);
    rdchk(8'h35, 8'h00);
    cmd(`FSR_CMD_WR_ALLOW);
    rdchk(8'h05, 8'h02);
    cmd(`FSR_CMD_WR_FORBID);
    rdchk(8'h05, 8'h00);
    wr(8'h01, 8'h1C, 1'b0, 1'b0);
    cmd(`FSR_CMD_WR_ALLOW);
    cmd(8'h01, 32'h1C000000, 2);
    rdchk(8'h05, 8'h1D);
    idle(`FSR_SR_WRITE_CYC);
    rdchk(8'h05, 8'h1C);
    chk(nv_image_o, 24'h20001C);
    chk(24'(cnt[1]), 24'h1);
    $display("Test done: latch");
    @(negedge sys_clk_i) high_throughput_mode_i = 1'b1;
    for (int v = 0; v < 4; v++) begin
      wr(8'h11, {1'b1, 2'(v), 5'h1F}, 1'b1, 1'b1);
      chk(24'(output_strength_o), 24'(v));
      rdchk(8'h15, {1'b0, 2'(v), 1'b1, 4'h0});
    end
    $display("Test done: strength");
    foreach (ptab[k]) begin
      wr(8'h31, ptab[k][47:40], 1'b1, 1'b1);
      wr(8'h01, ptab[k][39:32], 1'b1, 1'b1);
      wipe(`FSR_CMD_SECT_WIPE, ptab[k][31:8], 4, ptab[k][0]);
    end
    wipe(`FSR_CMD_FULL_WIPE_B, 24'h0, 1, 1'b0);
    wr(8'h01, 8'h1C, 1'b1, 1'b1);
    wipe(`FSR_CMD_FULL_WIPE_A, 24'h0, 1, 1'b1);
    chk(24'(array_op_o), 24'(FSR_OP_FULL));
    wr(8'h31, 8'h00, 1'b1, 1'b1);
    wipe(`FSR_CMD_FULL_WIPE_B, 24'h0, 1, 1'b0);
    wr(8'h01, 8'h00, 1'b1, 1'b1);
    $display("Test done: protect");
    cmd(`FSR_CMD_WR_ALLOW);
    cmd(`FSR_CMD_SECT_WIPE, 32'h01000000, 4);
    cmd(`FSR_CMD_SUSPEND);
    rdchk(8'h35, 8'h80);
    cmd(`FSR_CMD_RESUME);
    rdchk(8'h35, 8'h00);
    idle(80);
    cmd(`FSR_CMD_WR_ALLOW);
    cmd(`FSR_CMD_PAGE_WR, 32'h000100A5, 5);
    cmd(`FSR_CMD_SUSPEND);
    rdchk(8'h35, 8'h04);
    cmd(`FSR_CMD_RST_ENABLE);
    cmd(`FSR_CMD_RST);
    rdchk(8'h35, 8'h00);
    chk(24'(cnt[2] * 256 + cnt[3] * 16 + cnt[4]), 24'h211);
    $display("Test done: suspend");
    wr(8'h01, 8'h80, 1'b1, 1'b1);
    @(negedge sys_clk_i) write_guard_pin_n_i = 1'b0;
    wr(8'h01, 8'h84, 1'b1, 1'b0);
    @(negedge sys_clk_i) write_guard_pin_n_i = 1'b1;
    wr(8'h01, 8'h84, 1'b1, 1'b1);
    wr(8'h31, 8'h02, 1'b1, 1'b1);
    chk(24'(four_lane_enable_o), 24'h1);
    @(negedge sys_clk_i) write_guard_pin_n_i = 1'b0;
    wr(8'h01, 8'h80, 1'b1, 1'b1);
    @(negedge sys_clk_i) write_guard_pin_n_i = 1'b1;
    wr(8'h31, 8'h0A, 1'b1, 1'b1);
    wr(8'h31, 8'h00, 1'b1, 1'b1);
    chk(24'({four_lane_enable_o, security_lock_o}), 24'h1);
    wr(8'h01, 8'h00, 1'b1, 1'b1);
    wr(8'h31, 8'h01, 1'b1, 1'b1);
    wr(8'h01, 8'h04, 1'b1, 1'b0);
    pwr();
    rdchk(8'h35, 8'h08);
    wr(8'h01, 8'h00, 1'b1, 1'b1);
    $display("Test done: lock");
    wr(8'h01, 8'h80, 1'b1, 1'b1);
    wr(8'h31, 8'h09, 1'b1, 1'b1);
    wr(8'h01, 8'h00, 1'b1, 1'b0);
    pwr();
    wr(8'h01, 8'h00, 1'b1, 1'b0);
    $display("Test done: permanent");
    report_and_stop();
  end
endmodule
